/* sall_pkg.sv */
package sall_pkg;
   // table geometry
   localparam int TABLE_ENTRIES = 1024;
   localparam int MAC_W = 48;
   localparam int NPORTS = 3;
   localparam int PORT_W = 2;
   localparam int TS_W = 8;
   localparam int VID_W = 12;
   localparam int CFG_W = 16;

   // global control bit that enables aging
   localparam int AGING_EN_BIT = 10;

   // aging timing: coarse tick of a few seconds keeps the stamp narrow
   localparam longint CLK_HZ = 25_000_000;
   localparam int TICK_S = 4;
   localparam int AGING_S = 300;
   localparam int AGING_TOL_S = 75;
   localparam longint TICK_CYCLES_DEF = CLK_HZ * TICK_S;
   localparam logic [TS_W-1:0] AGE_TICKS = TS_W'(AGING_S / TICK_S);

   typedef logic [NPORTS-1:0] sall_pset_t;

   typedef enum logic [1:0] {
      SALL_IDLE = 2'h0,
      SALL_SCAN = 2'h1,
      SALL_DECIDE = 2'h2
   } sall_state_t;

   typedef struct packed {
      logic valid;
      logic [MAC_W-1:0] mac;
      logic [PORT_W-1:0] port;
      logic [TS_W-1:0] ts;
   } sall_entry_t;

   localparam sall_entry_t ENTRY_RST = '{valid: 1'b0, mac: '0, port: '0, ts: '0};

   // one received frame as delivered by the receive mac and the side tables
   typedef struct packed {
      logic [MAC_W-1:0] sa;
      logic [MAC_W-1:0] da;
      logic [PORT_W-1:0] src_port;
      logic [VID_W-1:0] vid;
      logic rx_err;
      logic len_ok;
      logic is_pause;
      logic static_hit;
      sall_pset_t static_ports;
      sall_pset_t vlan_ports;
      sall_pset_t stp_ports;
      sall_pset_t igmp_ports;
      sall_pset_t mirror_ports;
      sall_pset_t pvlan_ports;
   } sall_req_t;

   typedef struct packed {
      logic valid;
      logic drop;
      logic drop_err;
      logic drop_pause;
      logic drop_local;
      logic learned;
      logic migrated;
      sall_pset_t first_stage_port_set;
      sall_pset_t final_port_set;
   } sall_res_t;

   localparam sall_res_t RES_RST = '0;
   localparam sall_req_t REQ_RST = '0;
endpackage : sall_pkg

/* sall_tick_div.sv */
`timescale 1ns/10ps
module sall_tick_div #(
   parameter longint CYCLES = sall_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);
   import sall_pkg::*;

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = 1'b0;
      nxt_cnt = cnt_ff + CNT_W'(1);
      if (cnt_ff == LAST) begin
         nxt_cnt = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule : sall_tick_div

/* sall_lookup.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - table holds 1024 learned source addresses with port and time stamp
// - fully associative search, so every entry is usable for any address set
// - a new entry is added only when the source address is absent
// - learn or migrate only for error-free frames of legal length
// - a learned entry stores address, receiving port and current time stamp
// - when full, the oldest entry is replaced by the new address
// - known address on a different port gets its port field overwritten
// - time stamp refreshed whenever the address appears as source
// - background scan removes entries not refreshed within the aging period
// - aging period is 300 s nominal, tolerance 75 s either way
// - bit ten of the first global control word enables aging
// - stage one uses vlan, static and dynamic lookup to form first port set
// - stage two applies spanning tree, igmp, mirror and port vlan masks
// - frames with receive errors or illegal size are never forwarded
// - pause frames are consumed for flow control and never forwarded
// - frames whose destination resolves to the source port are dropped
module sall_lookup #(
   parameter int ENTRIES = sall_pkg::TABLE_ENTRIES,
   parameter longint TICK_CYCLES = sall_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [sall_pkg::CFG_W-1:0] global_switch_control_first,
   input wire logic req_valid,
   output logic req_ready,
   input sall_pkg::sall_req_t req,
   output sall_pkg::sall_res_t res,
   output logic pause_valid,
   output logic [sall_pkg::PORT_W-1:0] pause_port
);
   import sall_pkg::*;

   localparam int IDX_W = $clog2(ENTRIES);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(ENTRIES - 1);
   // clamp at half the stamp range: far above the expiry age, far below the wrap point
   localparam logic [TS_W-1:0] AGE_CAP = TS_W'(1 << (TS_W - 1));

   function automatic sall_pset_t port_mask(input logic [PORT_W-1:0] p);
      port_mask = sall_pset_t'(1) << p;
   endfunction : port_mask

   sall_entry_t tbl_ff [ENTRIES];

   sall_state_t state_ff, nxt_state;
   logic [IDX_W-1:0] idx_ff, nxt_idx;
   logic [IDX_W-1:0] age_ptr_ff, nxt_age_ptr;
   logic [TS_W-1:0] now_ff, nxt_now;
   sall_req_t req_ff, nxt_req;
   logic sa_hit_ff, nxt_sa_hit;
   logic [IDX_W-1:0] sa_idx_ff, nxt_sa_idx;
   logic [PORT_W-1:0] sa_port_ff, nxt_sa_port;
   logic da_hit_ff, nxt_da_hit;
   logic [PORT_W-1:0] da_port_ff, nxt_da_port;
   logic free_hit_ff, nxt_free_hit;
   logic [IDX_W-1:0] free_idx_ff, nxt_free_idx;
   logic [IDX_W-1:0] old_idx_ff, nxt_old_idx;
   logic [TS_W-1:0] old_age_ff, nxt_old_age;
   sall_res_t res_ff, nxt_res;
   logic pause_ff, nxt_pause;
   logic [PORT_W-1:0] pause_port_ff, nxt_pause_port;

   // single table write port, owned by the decide step
   logic tbl_we;
   logic [IDX_W-1:0] tbl_idx;
   sall_entry_t tbl_wdata;
   // aging clear, only issued while idle so it never meets a decide write
   logic age_clr;
   // with aging off the walk holds idle stamps at the cap instead of clearing them
   logic age_hold;
   logic [TS_W-1:0] held_ts;

   logic tick;
   logic aging_en;
   sall_entry_t cur;
   sall_entry_t aged;
   logic [TS_W-1:0] cur_age;
   logic [TS_W-1:0] aged_age;
   logic good;
   sall_pset_t src_mask;
   sall_pset_t first_set;
   sall_pset_t final_set;
   logic is_local;
   logic drop;

   sall_tick_div #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .nrst(nrst),
      .tick(tick)
   );

   assign aging_en = global_switch_control_first[AGING_EN_BIT];
   assign cur = tbl_ff[idx_ff];
   assign aged = tbl_ff[age_ptr_ff];
   // modular difference; with aging off the clamp, with aging on the clear, keeps every valid age well inside the stamp range
   assign cur_age = now_ff - cur.ts;
   assign aged_age = now_ff - aged.ts;
   assign req_ready = (state_ff == SALL_IDLE);

   // one entry examined per idle cycle; expiry is whole ticks so error stays within 4 s
   assign age_clr = (state_ff == SALL_IDLE) && aging_en && aged.valid
                    && (aged_age >= AGE_TICKS);

   // without the clamp an entry idle for a whole stamp period would wrap and look young,
   // and the oldest-entry choice would then spare it
   assign age_hold = (state_ff == SALL_IDLE) && !aging_en && aged.valid
                     && (aged_age > AGE_CAP);
   assign held_ts = now_ff - AGE_CAP;

   // frame classification for the decide step
   always_comb begin
      good = !req_ff.rx_err && req_ff.len_ok;
      src_mask = port_mask(req_ff.src_port);
      if (req_ff.static_hit) begin
         first_set = req_ff.static_ports;
      end else if (da_hit_ff) begin
         first_set = port_mask(da_port_ff);
      end else begin
         first_set = req_ff.vlan_ports;
      end
      is_local = (req_ff.static_hit || da_hit_ff) && (first_set == src_mask);
      final_set = ((first_set & req_ff.stp_ports & req_ff.igmp_ports & req_ff.pvlan_ports)
                   | req_ff.mirror_ports) & ~src_mask;
      drop = !good || req_ff.is_pause || is_local;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_age_ptr = age_ptr_ff;
      nxt_now = now_ff;
      nxt_req = req_ff;
      nxt_sa_hit = sa_hit_ff;
      nxt_sa_idx = sa_idx_ff;
      nxt_sa_port = sa_port_ff;
      nxt_da_hit = da_hit_ff;
      nxt_da_port = da_port_ff;
      nxt_free_hit = free_hit_ff;
      nxt_free_idx = free_idx_ff;
      nxt_old_idx = old_idx_ff;
      nxt_old_age = old_age_ff;
      nxt_res = res_ff;
      nxt_res.valid = 1'b0;
      nxt_pause = 1'b0;
      nxt_pause_port = pause_port_ff;
      tbl_we = 1'b0;
      tbl_idx = sa_idx_ff;
      tbl_wdata = ENTRY_RST;
      if (tick) begin
         nxt_now = now_ff + TS_W'(1);
      end
      case (state_ff)
         SALL_IDLE: begin
            // the walk only moves in idle cycles; under back-to-back traffic one step per frame
            nxt_age_ptr = age_ptr_ff + IDX_W'(1);
            if (age_ptr_ff == IDX_LAST) begin
               nxt_age_ptr = '0;
            end
            if (req_valid) begin
               nxt_req = req;
               nxt_idx = '0;
               nxt_sa_hit = 1'b0;
               nxt_da_hit = 1'b0;
               nxt_free_hit = 1'b0;
               nxt_old_idx = '0;
               nxt_old_age = '0;
               nxt_state = SALL_SCAN;
            end
         end
         SALL_SCAN: begin
            // exhaustive walk instead of hashing: no address is ever refused by collision
            if (cur.valid) begin
               if (cur.mac == req_ff.sa) begin
                  nxt_sa_hit = 1'b1;
                  nxt_sa_idx = idx_ff;
                  nxt_sa_port = cur.port;
               end
               if (cur.mac == req_ff.da) begin
                  nxt_da_hit = 1'b1;
                  nxt_da_port = cur.port;
               end
               if (cur_age >= old_age_ff) begin
                  nxt_old_idx = idx_ff;
                  nxt_old_age = cur_age;
               end
            end else if (!free_hit_ff) begin
               nxt_free_hit = 1'b1;
               nxt_free_idx = idx_ff;
            end
            if (idx_ff == IDX_LAST) begin
               nxt_state = SALL_DECIDE;
            end else begin
               nxt_idx = idx_ff + IDX_W'(1);
            end
         end
         SALL_DECIDE: begin
            tbl_wdata.valid = 1'b1;
            tbl_wdata.mac = req_ff.sa;
            tbl_wdata.ts = now_ff;
            tbl_wdata.port = sa_port_ff;
            // errored frames still refresh a known stamp; only good ones move or add an entry
            if (sa_hit_ff) begin
               tbl_we = 1'b1;
               tbl_idx = sa_idx_ff;
               if (good && (sa_port_ff != req_ff.src_port)) begin
                  tbl_wdata.port = req_ff.src_port;
               end
            end else if (good) begin
               tbl_we = 1'b1;
               tbl_idx = free_hit_ff ? free_idx_ff : old_idx_ff;
               tbl_wdata.port = req_ff.src_port;
            end
            nxt_res.valid = 1'b1;
            nxt_res.drop = drop;
            nxt_res.drop_err = !good;
            nxt_res.drop_pause = good && req_ff.is_pause;
            nxt_res.drop_local = good && !req_ff.is_pause && is_local;
            nxt_res.learned = good && !sa_hit_ff;
            nxt_res.migrated = good && sa_hit_ff && (sa_port_ff != req_ff.src_port);
            nxt_res.first_stage_port_set = first_set;
            nxt_res.final_port_set = drop ? '0 : final_set;
            nxt_pause = good && req_ff.is_pause;
            nxt_pause_port = req_ff.src_port;
            nxt_state = SALL_IDLE;
         end
         default: begin
            nxt_state = SALL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= SALL_IDLE;
         idx_ff <= '0;
         age_ptr_ff <= '0;
         now_ff <= '0;
         req_ff <= REQ_RST;
         sa_hit_ff <= 1'b0;
         sa_idx_ff <= '0;
         sa_port_ff <= '0;
         da_hit_ff <= 1'b0;
         da_port_ff <= '0;
         free_hit_ff <= 1'b0;
         free_idx_ff <= '0;
         old_idx_ff <= '0;
         old_age_ff <= '0;
         res_ff <= RES_RST;
         pause_ff <= 1'b0;
         pause_port_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         age_ptr_ff <= nxt_age_ptr;
         now_ff <= nxt_now;
         req_ff <= nxt_req;
         sa_hit_ff <= nxt_sa_hit;
         sa_idx_ff <= nxt_sa_idx;
         sa_port_ff <= nxt_sa_port;
         da_hit_ff <= nxt_da_hit;
         da_port_ff <= nxt_da_port;
         free_hit_ff <= nxt_free_hit;
         free_idx_ff <= nxt_free_idx;
         old_idx_ff <= nxt_old_idx;
         old_age_ff <= nxt_old_age;
         res_ff <= nxt_res;
         pause_ff <= nxt_pause;
         pause_port_ff <= nxt_pause_port;
      end
   end

   // per-entry storage; a decide write and an aging clear never share a cycle
   // clear and clamp exclude each other: one needs aging on, the other off
   for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
      sall_entry_t nxt_entry;
      always_comb begin
         nxt_entry = tbl_ff[i];
         if (tbl_we && (tbl_idx == IDX_W'(i))) begin
            nxt_entry = tbl_wdata;
         end else if (age_clr && (age_ptr_ff == IDX_W'(i))) begin
            nxt_entry.valid = 1'b0;
         end else if (age_hold && (age_ptr_ff == IDX_W'(i))) begin
            nxt_entry.ts = held_ts;
         end
      end
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            tbl_ff[i] <= ENTRY_RST;
         end else begin
            tbl_ff[i] <= nxt_entry;
         end
      end
   end

   assign res = res_ff;
   assign pause_valid = pause_ff;
   assign pause_port = pause_port_ff;
endmodule : sall_lookup

/* sall_lookup_sva.sv */
`timescale 1ns/10ps
module sall_lookup_sva #(
   parameter int ENTRIES = sall_pkg::TABLE_ENTRIES,
   parameter longint TICK_CYCLES = sall_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [sall_pkg::CFG_W-1:0] global_switch_control_first,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire sall_pkg::sall_req_t req,
   input wire sall_pkg::sall_res_t res,
   input wire logic pause_valid,
   input wire logic [sall_pkg::PORT_W-1:0] pause_port
);
   import sall_pkg::*;
   localparam int LAT = ENTRIES + 2;
   sall_req_t cap_ff;
   sall_req_t nxt_cap;
   int cnt_ff;
   int nxt_cnt;
   logic bad;
   sall_pset_t own;
   sall_pset_t exp_fin;
   // the request is only valid at its accept edge, so keep a copy for the result
   always_comb begin
      nxt_cap = cap_ff;
      nxt_cnt = req_ready ? 0 : cnt_ff + 1;
      if (req_valid && req_ready) begin
         nxt_cap = req;
         nxt_cnt = 1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cap_ff <= REQ_RST;
         cnt_ff <= 0;
      end else begin
         cap_ff <= nxt_cap;
         cnt_ff <= nxt_cnt;
      end
   end
   assign bad = cap_ff.rx_err || !cap_ff.len_ok;
   assign own = sall_pset_t'(1 << cap_ff.src_port);
   assign exp_fin = ((res.first_stage_port_set & cap_ff.stp_ports & cap_ff.igmp_ports
      & cap_ff.pvlan_ports) | cap_ff.mirror_ports) & ~own;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_res_latency: assert property (res.valid |-> cnt_ff == LAT)
      else $error("result off time");
   chk_busy_bound: assert property (!req_ready |-> cnt_ff < LAT)
      else $error("busy too long");
   chk_err_drop: assert property (res.valid && bad |-> res.drop && res.drop_err
      && res.final_port_set == '0 && !res.learned && !res.migrated)
      else $error("error frame passed");
   chk_pause_eaten: assert property (res.valid && cap_ff.is_pause && !bad
      |-> pause_valid && pause_port == cap_ff.src_port && res.final_port_set == '0)
      else $error("pause not consumed");
   chk_pause_only: assert property (pause_valid |-> res.valid && cap_ff.is_pause)
      else $error("stray pause");
   chk_stage_two: assert property (res.valid && !res.drop |-> res.final_port_set == exp_fin)
      else $error("final set wrong");
   chk_static_first: assert property (res.valid && cap_ff.static_hit
      |-> res.first_stage_port_set == cap_ff.static_ports)
      else $error("static set wrong");
   chk_no_selfsend: assert property (res.valid |-> (res.final_port_set & own) == '0)
      else $error("sent to source");
   chk_one_update: assert property (res.valid |-> !(res.learned && res.migrated))
      else $error("learn and migrate");
   chk_res_hold: assert property (!res.valid |-> $stable(res.final_port_set))
      else $error("result moved");
endmodule : sall_lookup_sva

bind sall_lookup sall_lookup_sva #(.ENTRIES(ENTRIES), .TICK_CYCLES(TICK_CYCLES)) i_sva (
   .clk(clk), .nrst(nrst), .global_switch_control_first(global_switch_control_first),
   .req_valid(req_valid), .req_ready(req_ready), .req(req), .res(res),
   .pause_valid(pause_valid), .pause_port(pause_port));

/* sall_mac_model.sv */
`timescale 1ns/10ps
module sall_mac_model (
   input wire logic clk,
   input wire logic req_ready,
   output logic req_valid,
   output sall_pkg::sall_req_t req
);
   import sall_pkg::*;
   initial begin
      req_valid = 1'b0;
      req = REQ_RST;
   end
   // frame info held until the accept edge, then scrambled so stale data is never reused
   task automatic send(input sall_req_t r);
      req = r;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      req = ~r;
   endtask : send
endmodule : sall_mac_model

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
   import sall_pkg::*;
   localparam int N = 8;
   logic clk;
   logic nrst;
   logic rv;
   logic rr;
   logic pv;
   logic [CFG_W-1:0] cfg;
   logic [PORT_W-1:0] pp;
   sall_req_t rq;
   sall_res_t rs;
   sall_req_t r;
   int fails;
   int n_compared;
   int cyc;
   sall_lookup #(.ENTRIES(N), .TICK_CYCLES(20)) i_dut (.clk(clk), .nrst(nrst),
      .global_switch_control_first(cfg), .req_valid(rv), .req_ready(rr), .req(rq),
      .res(rs), .pause_valid(pv), .pause_port(pp));
   sall_mac_model i_mac (.clk(clk), .req_ready(rr), .req_valid(rv), .req(rq));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic sall_req_t mk(input logic [7:0] s, input logic [7:0] d,
         input logic [1:0] p);
      sall_req_t m;
      m = REQ_RST;
      m.sa = {40'h0, s};
      m.da = {40'h0, d};
      m.src_port = p;
      m.len_ok = 1'b1;
      m.vlan_ports = 3'h7;
      m.stp_ports = 3'h7;
      m.igmp_ports = 3'h7;
      m.pvlan_ports = 3'h7;
      return m;
   endfunction : mk
   task automatic rst();
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
   endtask : rst
   task automatic xfer(input sall_req_t q);
      int k;
      i_mac.send(q);
      chk("req_ready", rr, 8'h00);
      k = 0;
      while (rs.valid !== 1'b1 && k < N + 4) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("res_valid", rs.valid, 8'h01);
      chk("req_ready", rr, 8'h01);
   endtask : xfer
   task automatic ck(input sall_req_t q, input sall_pset_t f, input sall_pset_t fin,
         input logic [5:0] fl);
      logic [5:0] g;
      xfer(q);
      g = {rs.drop, rs.drop_err, rs.drop_pause, rs.drop_local, rs.learned, rs.migrated};
      chk("first_stage_port_set", rs.first_stage_port_set, f);
      chk("final_port_set", rs.final_port_set, fin);
      chk("flags", g, fl);
   endtask : ck
   task automatic lk(input logic [7:0] s, input logic [7:0] d, input logic [1:0] p,
         input sall_pset_t f);
      xfer(mk(s, d, p));
      chk("first_stage_port_set", rs.first_stage_port_set, f);
   endtask : lk
   task automatic t_learn();
      ck(mk(8'h01, 8'h09, 2'h0), 3'h7, 3'h6, 6'h02);
      ck(mk(8'h02, 8'h01, 2'h1), 3'h1, 3'h1, 6'h02);
      ck(mk(8'h01, 8'h09, 2'h2), 3'h7, 3'h3, 6'h01);
      ck(mk(8'h02, 8'h01, 2'h1), 3'h4, 3'h4, 6'h00);
      ck(mk(8'h01, 8'h01, 2'h2), 3'h4, 3'h0, 6'h24);
   endtask : t_learn
   task automatic t_filter();
      r = mk(8'h03, 8'h09, 2'h0);
      r.rx_err = 1'b1;
      ck(r, 3'h7, 3'h0, 6'h30);
      r.rx_err = 1'b0;
      r.len_ok = 1'b0;
      ck(r, 3'h7, 3'h0, 6'h30);
      lk(8'h04, 8'h03, 2'h1, 3'h7);
      r = mk(8'h02, 8'h09, 2'h0);
      r.rx_err = 1'b1;
      ck(r, 3'h7, 3'h0, 6'h30);
      lk(8'h04, 8'h02, 2'h1, 3'h2);
      r = mk(8'h02, 8'h09, 2'h1);
      r.is_pause = 1'b1;
      ck(r, 3'h7, 3'h0, 6'h28);
      chk("pause", {pv, pp}, 8'h05);
      r = mk(8'h02, 8'h09, 2'h1);
      r.static_hit = 1'b1;
      r.static_ports = 3'h3;
      r.stp_ports = 3'h1;
      r.mirror_ports = 3'h4;
      ck(r, 3'h3, 3'h5, 6'h00);
      r.static_ports = 3'h2;
      ck(r, 3'h2, 3'h0, 6'h24);
      r = mk(8'h02, 8'h09, 2'h1);
      r.igmp_ports = 3'h5;
      r.pvlan_ports = 3'h3;
      ck(r, 3'h7, 3'h1, 6'h00);
   endtask : t_filter
   task automatic t_full();
      int i;
      rst();
      // addresses differ only in low bits, the worst case for a hashed table
      for (i = 0; i < N; i++) begin
         r = mk(8'h10 + 8'(i), 8'h09, 2'(i % 3));
         ck(r, 3'h7, ~(3'h1 << (i % 3)), 6'h02);
      end
      for (i = 0; i < N; i++) begin
         lk(8'h10 + 8'((i + 1) % N), 8'h10 + 8'(i), 2'(((i + 1) % N) % 3),
            3'h1 << (i % 3));
      end
      ck(mk(8'h30, 8'h09, 2'h0), 3'h7, 3'h6, 6'h02);
      lk(8'h17, 8'h30, 2'h1, 3'h1);
      // 11 and 12 share the oldest stamp; the higher index gives way
      lk(8'h16, 8'h12, 2'h0, 3'h7);
      lk(8'h16, 8'h11, 2'h0, 3'h2);
   endtask : t_full
   task automatic t_age();
      repeat (1600) @(posedge clk);
      #1;
      lk(8'h17, 8'h30, 2'h1, 3'h1);
      ck(mk(8'h30, 8'h09, 2'h0), 3'h7, 3'h6, 6'h00);
      cfg[AGING_EN_BIT] = 1'b1;
      repeat (1200) @(posedge clk);
      #1;
      lk(8'h17, 8'h30, 2'h1, 3'h1);
      repeat (400) @(posedge clk);
      #1;
      lk(8'h17, 8'h30, 2'h1, 3'h7);
   endtask : t_age
   initial begin
      nrst = 1'b0;
      cfg = 16'h0000;
      rst();
      t_learn();
      t_filter();
      t_full();
      t_age();
      tally_and_finish();
   end
endmodule : testbench
